// *** dsrw_status.v ***
// Drive status word, reference decode and actual-value words
//
// Functional notes
// - Sixteen-bit status word, low eight state flags
// - Bit zero clear when not ready
// - On-target when error within ten percent of nominal in speed control, else exact match only
// - Remote flag set for external locations
// - Above-limit when speed reaches supervision limit
// - Location select shows second external location
// - Run permit follows external run enable
// - Bits thirteen, fourteen user programmable
// - Top bit shows fieldbus link fault
// - Reference is a two's complement word, sign in the top bit
// - 0..20000 maps to 0..100 percent
// - Actual words carry selected monitored quantities
// - Reset bit rising edge clears fault when fieldbus is the source
`timescale 1ns/10ps
`default_nettype none
`include "dsrw_regs.vh"
module dsrw_status
(
    input wire clk_i,
    input wire rst_b_i,
    input wire rdy_on_i,
    input wire rdy_run_i,
    input wire rdy_ref_i,
    input wire fault_i,
    input wire coast_stop_inactive_i,
    input wire quick_stop_inactive_i,
    input wire switch_on_inhibit_i,
    input wire alarm_i,
    input wire speed_ctrl_i,
    input wire [15:0] actual_speed_i,
    input wire [15:0] nominal_speed_i,
    input wire local_ctrl_i,
    input wire second_location_i,
    input wire [15:0] supervision_limit_i,
    input wire run_enable_pin_i,
    input wire [1:0] user_bits_i,
    input wire [1:0] user_bits_en_i,
    input wire link_error_i,
    input wire fieldbus_source_i,
    input wire [15:0] control_word_i,
    input wire [15:0] speed_setpoint_word_i,
    input wire [15:0] speed_scale_i,
    input wire [1:0] act_sel_i,
    input wire [15:0] act_src0_i,
    input wire [15:0] act_src1_i,
    input wire [15:0] act_src2_i,
    input wire [15:0] act_src3_i,
    output reg [15:0] drive_status_word_o,
    output reg [15:0] actual_word_o,
    output wire [15:0] ref_magnitude_o,
    output wire ref_reverse_o,
    output reg fault_reset_o
);
    // ****************************************
    // Input synchronisers
    // ****************************************
    reg run_en_s1_r;
    reg run_en_s2_r;
    reg link_err_s1_r;
    reg link_err_s2_r;
    reg rst_bit_d_r;
    always @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            run_en_s1_r <= 1'b0;
            run_en_s2_r <= 1'b0;
            link_err_s1_r <= 1'b0;
            link_err_s2_r <= 1'b0;
        end
        else
        begin
            run_en_s1_r <= run_enable_pin_i;
            run_en_s2_r <= run_en_s1_r;
            link_err_s1_r <= link_error_i;
            link_err_s2_r <= link_err_s1_r;
        end
    end

    // ****************************************
    // Helpers
    // ****************************************
    function [15:0] dsrw_abs;
        input [15:0] v;
        begin
            dsrw_abs = v[15] ? (~v + 16'h0001) : v;
        end
    endfunction

    // ****************************************
    // Reference scaling
    // ****************************************
    wire [15:0] sp_mag;
    wire sp_neg;
    dsrw_scale u_scale
    (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .ref_word_i(speed_setpoint_word_i),
        .scale_i(speed_scale_i),
        .mag_o(sp_mag),
        .neg_o(sp_neg)
    );

    // ****************************************
    // Reference outputs
    // ****************************************
    // Registered so the outputs come from flops, at one more cycle of latency
    reg [15:0] ref_mag_r;
    reg ref_rev_r;
    always @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            ref_mag_r <= 16'h0000;
            ref_rev_r <= 1'b0;
        end
        else
        begin
            // Fieldbus reference ignored unless fieldbus is the source
            ref_mag_r <= fieldbus_source_i ? sp_mag : 16'h0000;
            ref_rev_r <= fieldbus_source_i & sp_neg;
        end
    end
    assign ref_magnitude_o = ref_mag_r;
    assign ref_reverse_o = ref_rev_r;

    // ****************************************
    // Status flag logic
    // ****************************************
    reg [15:0] act_abs;
    reg [16:0] err_abs;
    reg [31:0] err_x100;
    reg [31:0] tol_x;
    reg on_target;
    reg [15:0] status_nxt;
    reg [15:0] act_nxt;
    always @*
    begin
        act_abs = dsrw_abs(actual_speed_i);
        // Compare signed actual against signed reference magnitude
        if (sp_neg == actual_speed_i[15])
            err_abs = {1'b0, (act_abs > sp_mag) ? act_abs - sp_mag : sp_mag - act_abs};
        else
            // Opposite signs add, so one extra bit keeps the carry
            err_abs = {1'b0, act_abs} + {1'b0, sp_mag};
        err_x100 = {15'h0000, err_abs} * 32'd100;
        tol_x = {16'h0000, nominal_speed_i} * {16'h0000, `DSRW_TOL_PERCENT};
        // Outside speed control no tolerance applies, so exact match only
        on_target = speed_ctrl_i ? (err_x100 <= tol_x) : (err_abs == 17'h00000);
        status_nxt = `DSRW_STATUS_RESET;
        status_nxt[`DSRW_BIT_RDY_ON] = rdy_on_i;
        status_nxt[`DSRW_BIT_RDY_RUN] = rdy_run_i;
        status_nxt[`DSRW_BIT_RDY_REF] = rdy_ref_i;
        status_nxt[`DSRW_BIT_FAULT] = fault_i;
        status_nxt[`DSRW_BIT_COAST_INACT] = coast_stop_inactive_i;
        status_nxt[`DSRW_BIT_QSTOP_INACT] = quick_stop_inactive_i;
        status_nxt[`DSRW_BIT_SW_INHIBIT] = switch_on_inhibit_i;
        status_nxt[`DSRW_BIT_ALARM] = alarm_i;
        status_nxt[`DSRW_BIT_ON_TARGET] = on_target;
        status_nxt[`DSRW_BIT_REMOTE] = ~local_ctrl_i;
        status_nxt[`DSRW_BIT_ABOVE_LIMIT] = act_abs >= supervision_limit_i;
        status_nxt[`DSRW_BIT_LOC_SELECT] = ~local_ctrl_i & second_location_i;
        status_nxt[`DSRW_BIT_RUN_PERMIT] = run_en_s2_r;
        status_nxt[`DSRW_BIT_USER0] = user_bits_en_i[0] & user_bits_i[0];
        status_nxt[`DSRW_BIT_USER1] = user_bits_en_i[1] & user_bits_i[1];
        status_nxt[`DSRW_BIT_LINK_FAULT] = link_err_s2_r;
    end

    // ****************************************
    // Actual value select
    // ****************************************
    always @*
    begin
        case (act_sel_i)
            2'h0: act_nxt = act_src0_i;
            2'h1: act_nxt = act_src1_i;
            2'h2: act_nxt = act_src2_i;
            2'h3: act_nxt = act_src3_i;
            default: act_nxt = `DSRW_ACT_RESET;
        endcase
    end

    // ****************************************
    // Registered outputs
    // ****************************************
    always @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            drive_status_word_o <= `DSRW_STATUS_RESET;
            actual_word_o <= `DSRW_ACT_RESET;
        end
        else
        begin
            drive_status_word_o <= status_nxt;
            actual_word_o <= act_nxt;
        end
    end

    // ****************************************
    // Fault reset edge detect
    // ****************************************
    // Delay flop resets to 0, so a reset bit already high after reset is taken as a rising edge
    always @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            rst_bit_d_r <= 1'b0;
            fault_reset_o <= 1'b0;
        end
        else
        begin
            rst_bit_d_r <= control_word_i[`DSRW_CW_RESET_BIT];
            // Pulse only on 0->1 with an active fault
            fault_reset_o <= fieldbus_source_i & fault_i & ~rst_bit_d_r
                & control_word_i[`DSRW_CW_RESET_BIT];
        end
    end
endmodule // dsrw_status
`default_nettype wire

// *** dsrw_regs.vh ***
// Bit positions, scaling and reset values for the drive status and reference words
`ifndef DSRW_REGS_VH
`define DSRW_REGS_VH
`define DSRW_BIT_RDY_ON 0
`define DSRW_BIT_RDY_RUN 1
`define DSRW_BIT_RDY_REF 2
`define DSRW_BIT_FAULT 3
`define DSRW_BIT_COAST_INACT 4
`define DSRW_BIT_QSTOP_INACT 5
`define DSRW_BIT_SW_INHIBIT 6
`define DSRW_BIT_ALARM 7
`define DSRW_BIT_ON_TARGET 8
`define DSRW_BIT_REMOTE 9
`define DSRW_BIT_ABOVE_LIMIT 10
`define DSRW_BIT_LOC_SELECT 11
`define DSRW_BIT_RUN_PERMIT 12
`define DSRW_BIT_USER0 13
`define DSRW_BIT_USER1 14
`define DSRW_BIT_LINK_FAULT 15
`define DSRW_CW_RESET_BIT 7
`define DSRW_REF_FULL_SCALE 16'd20000
`define DSRW_TOL_PERCENT 16'd10
`define DSRW_STATUS_RESET 16'h0000
`define DSRW_ACT_RESET 16'h0000
`endif

// *** dsrw_scale.v ***
// Two's complement reference scaling: 0..20000 maps to 0..100 % of scaling value
`timescale 1ns/10ps
`default_nettype none
`include "dsrw_regs.vh"
module dsrw_scale
(
    input wire clk_i,
    input wire rst_b_i,
    input wire [15:0] ref_word_i,
    input wire [15:0] scale_i,
    output reg [15:0] mag_o,
    output reg neg_o
);
    reg [15:0] abs_w;
    reg [31:0] prod_w;
    reg [31:0] quot_w;
    always @*
    begin
        // Negative words are two's complement of the positive value
        abs_w = ref_word_i[15] ? (~ref_word_i + 16'h0001) : ref_word_i;
        prod_w = abs_w * scale_i;
        quot_w = prod_w / {16'h0000, `DSRW_REF_FULL_SCALE};
    end
    always @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            mag_o <= 16'h0000;
            neg_o <= 1'b0;
        end
        else
        begin
            // Saturate rather than wrap when a reference above full scale overflows 16 bits
            mag_o <= (quot_w > 32'h0000ffff) ? 16'hffff : quot_w[15:0];
            neg_o <= ref_word_i[15];
        end
    end
endmodule // dsrw_scale
`default_nettype wire

// *** dsrw_status_checker.sv ***
// Concurrent checks on the drive status word block ports
`timescale 1ns/10ps
`default_nettype none
module dsrw_status_checker
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic rdy_on_i,
    input wire logic fault_i,
    input wire logic local_ctrl_i,
    input wire logic second_location_i,
    input wire logic [15:0] actual_speed_i,
    input wire logic [15:0] supervision_limit_i,
    input wire logic run_enable_pin_i,
    input wire logic link_error_i,
    input wire logic [1:0] user_bits_i,
    input wire logic [1:0] user_bits_en_i,
    input wire logic fieldbus_source_i,
    input wire logic [15:0] control_word_i,
    input wire logic [15:0] drive_status_word_o,
    input wire logic fault_reset_o
);
    // Magnitude, so the limit holds in both directions
    wire logic [15:0] spd_abs = actual_speed_i[15] ? -actual_speed_i : actual_speed_i;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    AST_RDY: assert property (!rdy_on_i |=> !drive_status_word_o[0])
        else $error("ready flag set while not ready");
    AST_REM: assert property (1 |=> drive_status_word_o[9] == !$past(local_ctrl_i))
        else $error("remote flag wrong");
    AST_LOC: assert property (1 |=> drive_status_word_o[11] == $past(second_location_i & !local_ctrl_i))
        else $error("location flag wrong");
    AST_LIM: assert property (1 |=> drive_status_word_o[10] == $past(spd_abs >= supervision_limit_i))
        else $error("limit flag wrong");
    AST_RUN: assert property (run_enable_pin_i [*3] |=> drive_status_word_o[12])
        else $error("run permit missing");
    AST_LNK: assert property (!link_error_i [*3] |=> !drive_status_word_o[15])
        else $error("link fault without error");
    AST_USR: assert property (1 |=> drive_status_word_o[14:13] == $past(user_bits_i & user_bits_en_i))
        else $error("user bits wrong");
    AST_FRS: assert property ($rose(control_word_i[7]) && fault_i && fieldbus_source_i |=> fault_reset_o ##1 !fault_reset_o)
        else $error("fault reset pulse wrong");
    cover property (fault_reset_o);
    cover property (drive_status_word_o[8]);
    cover property (drive_status_word_o[10]);
endmodule // dsrw_status_checker
bind dsrw_status dsrw_status_checker u_chk (.*);
`default_nettype wire

// *** dsrw_client.sv ***
// Fieldbus client model: encodes speed requests and the reset command
`timescale 1ns/10ps
`default_nettype none
module dsrw_client
(
    input wire logic clk_i,
    input wire logic [14:0] mag_i,
    input wire logic rev_i,
    input wire logic reset_req_i,
    input wire logic select_i,
    output var logic [15:0] control_word_o,
    output var logic [15:0] setpoint_word_o,
    output var logic source_o
);
    always @(posedge clk_i)
    begin
        // Reverse goes out as two's complement of the forward word
        setpoint_word_o <= rev_i ? 16'h0 - {1'b0, mag_i} : {1'b0, mag_i};
        control_word_o <= {8'h00, reset_req_i, 7'h00};
        source_o <= select_i;
    end
endmodule // dsrw_client
`default_nettype wire

// *** tb.sv ***
// Random and directed bench for the drive status word block
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clk_i = 0, rst_b_i = 0, speed_ctrl_i = 0, local_ctrl_i = 0, second_location_i = 0;
    logic run_enable_pin_i = 0, link_error_i = 0, rq = 0, rv = 0, sel = 0;
    logic [7:0] flg = 0;
    logic [1:0] user_bits_i = 0, user_bits_en_i = 0, act_sel_i = 0;
    logic [14:0] m = 0;
    logic [15:0] actual_speed_i = 0, nominal_speed_i = 0, supervision_limit_i = 0;
    logic [15:0] speed_scale_i = 0, cnt, control_word_i, speed_setpoint_word_i;
    logic [15:0] drive_status_word_o, actual_word_o, ref_magnitude_o;
    logic [3:0][15:0] src = 0;
    logic [3:0][15:0] ot = {16'h06a4, 16'h060e, 16'h05dd, 16'h05dc};
    logic fieldbus_source_i, ref_reverse_o, fault_reset_o;
    int err_count = 0, n_checks = 0;
    dsrw_client u_cli (.clk_i, .mag_i(m), .rev_i(rv), .reset_req_i(rq), .select_i(sel),
        .control_word_o(control_word_i), .setpoint_word_o(speed_setpoint_word_i),
        .source_o(fieldbus_source_i));
    dsrw_status u_dut (.*, .rdy_on_i(flg[0]), .rdy_run_i(flg[1]), .rdy_ref_i(flg[2]),
        .fault_i(flg[3]), .coast_stop_inactive_i(flg[4]), .quick_stop_inactive_i(flg[5]),
        .switch_on_inhibit_i(flg[6]), .alarm_i(flg[7]), .act_src0_i(src[0]),
        .act_src1_i(src[1]), .act_src2_i(src[2]), .act_src3_i(src[3]));
    initial forever #10 clk_i = ~clk_i;
    function automatic logic [15:0] exp_sw();
        logic [15:0] a;
        a = actual_speed_i[15] ? -actual_speed_i : actual_speed_i;
        return {link_error_i, user_bits_i & user_bits_en_i, run_enable_pin_i,
            second_location_i & !local_ctrl_i, a >= supervision_limit_i, !local_ctrl_i, 1'b0, flg};
    endfunction
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    task end_sim();
        $display("errors %0d checks %0d", err_count, n_checks);
        if (err_count == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        #200000;
        err_count++;
        end_sim();
    end
    initial
    begin
        void'($urandom(32'h5077));
        repeat (7) @(posedge clk_i);
        #1 chk("reset", 16'h0000, drive_status_word_o | actual_word_o | ref_magnitude_o);
        @(posedge clk_i);
        rst_b_i <= 1;
        repeat (150)
        begin
            @(posedge clk_i);
            {flg, speed_ctrl_i, local_ctrl_i, second_location_i, run_enable_pin_i} <= 12'($urandom);
            {link_error_i, rv, user_bits_i, user_bits_en_i, act_sel_i, sel} <= 9'($urandom);
            {actual_speed_i, supervision_limit_i} <= $urandom;
            {speed_scale_i, nominal_speed_i} <= $urandom;
            src <= {$urandom, $urandom};
            m <= 15'($urandom_range(20000));
            repeat (5) @(posedge clk_i);
            #1 chk("status", exp_sw(), drive_status_word_o & 16'hfeff);
            chk("ref_mag", sel ? 16'(32'(m) * speed_scale_i / 32'h4e20) : 16'h0, ref_magnitude_o);
            chk("ref_rev", {15'h0, sel & rv & (m != 0)}, {15'h0, ref_reverse_o});
            chk("actual", src[act_sel_i], actual_word_o);
        end
        @(posedge clk_i);
        {sel, rv, m, speed_scale_i, nominal_speed_i} <= {2'b10, 15'h4e20, 16'h05dc, 16'h03e8};
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk_i);
            speed_ctrl_i <= i[1];
            actual_speed_i <= ot[i];
            repeat (5) @(posedge clk_i);
            #1 chk("on_target", {15'h0, !i[0]}, {15'h0, drive_status_word_o[8]});
        end
        // Rising reset bit acts only with a fault and the fieldbus as source
        for (int f = 0; f < 3; f++)
        begin
            @(posedge clk_i);
            flg[3] <= f != 0;
            sel <= f != 2;
            rq <= 0;
            repeat (3) @(posedge clk_i);
            rq <= 1;
            cnt = 0;
            repeat (6)
            begin
                @(posedge clk_i);
                #1 cnt += fault_reset_o;
            end
            chk("fault_reset", {15'h0, f == 1}, cnt);
        end
        end_sim();
    end
endmodule // tb
`default_nettype wire
